// ### verilog/usx_core.sv
// serial transceiver core with apb registers, fractional divisor and rx fifo
// Function
// - divisor is division factor times 64; low six bits are fraction
// - synchronous mode uses only divisor bits 15:6; fraction written zero
// - async rate is 64 times clock over samples-per-bit times divisor
// - sync host rate is clock over twice integer divisor
// - written data goes to buffer, then shift register, then is sent
// - transmit complete set when frame done and nothing pending
// - unused upper bits ignored for characters under eight bits
// - transmitter disable waits for empty path, then releases pin
// - receiver starts on valid start bit, ignores second stop bit
// - first stop bit moves frame to buffer and sets receive complete
// - receive buffer holds two frames, oldest shown first
// - low-first nine-bit: high byte read advances; else low byte read
// - frame, overflow and parity error stored per frame, read in high byte
// - overflow on arrival with full buffer; parity error on mismatch
// - receiver disable is immediate, flushes buffer and frame in progress
// - four async reception modes; one double speed with eight samples
// - transfer clock pin direction selects host or client; here control bit CTRL_HOST selects it and, with CTRL_SYNC set, drives xck_oe_n
// - sync receive samples on edge opposite to transmit change
// - frame: start low, 5 to 9 data, optional parity, 1 or 2 stops
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module usx_core #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_in,
  output logic txd_out,
  output logic txd_oe_n,
  input wire logic xck_in,
  output logic xck_out,
  output logic xck_oe_n
);
  generate
    if (ADDR_W < 5 || ADDR_W > 32)
    begin : g_bad_addr
      $error("usx_core: ADDR_W must be 5 to 32");
    end
  endgenerate

  logic tx_en, rx_en, sync_mode, host_mode, stop2, txc;
  logic [1:0] rx_mode, parity_mode;
  logic [2:0] char_size;
  logic [15:0] baud;
  logic [7:0] addr;
  logic xfer, wr, rd, mapped;
  logic nine, par_en;
  logic [3:0] nbits, spb_m1;
  logic [8:0] dmask;

  assign addr = 8'(paddr);
  assign xfer = psel & penable & pready;
  assign wr = xfer & pwrite;
  assign rd = xfer & ~pwrite;
  assign mapped = addr == usx_pkg::OFS_DATA_LOW || addr == usx_pkg::OFS_DATA_HIGH ||
                  addr == usx_pkg::OFS_STATUS || addr == usx_pkg::OFS_CTRL ||
                  addr == usx_pkg::OFS_FRAME || addr == usx_pkg::OFS_BAUD;
  assign nine = char_size[2];
  assign par_en = parity_mode[1];
  assign nbits = nine ? 4'd9 : 4'd5 + {2'b00, char_size[1:0]};
  assign spb_m1 = (rx_mode == usx_pkg::RXM_DOUBLE) ? 4'(usx_pkg::S_DOUBLE - 1)
                                                   : 4'(usx_pkg::S_NORMAL - 1);

  // mask of used data bits
  generate
    for (genvar i = 0; i < usx_pkg::DATA_MAX; i++)
    begin : g_mask
      assign dmask[i] = 4'(i) < nbits;
    end
  endgenerate

  // fractional sample tick: 64 / divisor ticks per clock
  logic [16:0] acc, next_acc;
  logic smp_tick;
  assign next_acc = acc + 17'(usx_pkg::FRAC_STEP);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc <= '0;
      smp_tick <= 1'b0;
    end
    else if (pclken)
    begin
      if (next_acc >= {1'b0, baud})
      begin
        acc <= next_acc - {1'b0, baud};
        smp_tick <= 1'b1;
      end
      else
      begin
        acc <= next_acc;
        smp_tick <= 1'b0;
      end
    end
  end

  // synchronous host clock, one phase per integer divisor count
  logic [9:0] hcnt;
  logic half_wrap, xck_q, xck_src, xck_rise, xck_fall;
  assign half_wrap = hcnt + 10'd1 >= baud[15:6];
  assign xck_src = host_mode ? xck_out : xck_in;
  assign xck_rise = xck_src & ~xck_q;
  assign xck_fall = ~xck_src & xck_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hcnt <= '0;
      xck_out <= 1'b0;
      xck_oe_n <= 1'b1;
      xck_q <= 1'b0;
    end
    else if (pclken)
    begin
      xck_q <= xck_src;
      xck_oe_n <= ~(sync_mode & host_mode);
      if (!(sync_mode && host_mode))
      begin
        hcnt <= '0;
        xck_out <= 1'b0;
      end
      else if (half_wrap)
      begin
        hcnt <= '0;
        xck_out <= ~xck_out;
      end
      else
        hcnt <= hcnt + 10'd1;
    end
  end

  // transmit bit strobe
  logic [3:0] ttick;
  logic tx_strobe;
  assign tx_strobe = sync_mode ? xck_rise : (smp_tick && ttick == spb_m1);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ttick <= '0;
    else if (pclken && smp_tick)
      ttick <= (ttick == spb_m1) ? 4'd0 : ttick + 4'd1;
  end

  // transmit data registers and buffer
  logic [8:0] tx_hold, tx_buf, tx_shift;
  logic hold_full, buf_full, tx_load, tx_done, wr_low, wr_high, wr_done;
  usx_pkg::usx_tx_e tx_state;
  logic [3:0] tbit;
  logic tstop;
  assign wr_low = wr && addr == usx_pkg::OFS_DATA_LOW && !hold_full;
  assign wr_high = wr && addr == usx_pkg::OFS_DATA_HIGH && !hold_full;
  assign wr_done = (char_size == usx_pkg::CS_9L) ? wr_high : wr_low;
  assign tx_done = tx_state == usx_pkg::TX_STOP && (!stop2 || tstop);
  assign tx_load = tx_strobe && !txd_oe_n && buf_full &&
                   (tx_state == usx_pkg::TX_IDLE || tx_done);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_hold <= '0;
      tx_buf <= '0;
      hold_full <= 1'b0;
      buf_full <= 1'b0;
    end
    else if (pclken)
    begin
      if (wr_low)
        tx_hold[7:0] <= pwdata[7:0];
      if (wr_high)
        tx_hold[8] <= pwdata[0];
      if (hold_full && (!buf_full || tx_load))
      begin
        tx_buf <= tx_hold;
        buf_full <= 1'b1;
        hold_full <= 1'b0;
      end
      else
      begin
        if (tx_load)
          buf_full <= 1'b0;
        if (wr_done)
          hold_full <= 1'b1;
      end
    end
  end

  // transmit shifter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state <= usx_pkg::TX_IDLE;
      tx_shift <= '0;
      tbit <= '0;
      tstop <= 1'b0;
      txd_out <= 1'b1;
    end
    else if (pclken)
    begin
      if (tx_load)
        tx_shift <= tx_buf & dmask;
      if (txd_oe_n)
      begin
        tx_state <= usx_pkg::TX_IDLE;
        txd_out <= 1'b1;
      end
      else if (tx_strobe)
      begin
        unique case (tx_state)
          usx_pkg::TX_IDLE:
            if (buf_full)
            begin
              tx_state <= usx_pkg::TX_START;
              txd_out <= 1'b0;
            end
          usx_pkg::TX_START:
          begin
            tx_state <= usx_pkg::TX_DATA;
            txd_out <= tx_shift[0];
            tbit <= 4'd1;
          end
          usx_pkg::TX_DATA:
            if (tbit == nbits)
            begin
              tx_state <= par_en ? usx_pkg::TX_PAR : usx_pkg::TX_STOP;
              txd_out <= par_en ? (^tx_shift) ^ parity_mode[0] : 1'b1;
              tstop <= 1'b0;
            end
            else
            begin
              txd_out <= tx_shift[tbit];
              tbit <= tbit + 4'd1;
            end
          usx_pkg::TX_PAR:
          begin
            tx_state <= usx_pkg::TX_STOP;
            txd_out <= 1'b1;
          end
          usx_pkg::TX_STOP:
            if (!tx_done)
              tstop <= 1'b1;
            else if (buf_full)
            begin
              tx_state <= usx_pkg::TX_START;
              txd_out <= 1'b0;
            end
            else
              tx_state <= usx_pkg::TX_IDLE;
          default:
          begin
            tx_state <= usx_pkg::TX_IDLE;
            txd_out <= 1'b1;
          end
        endcase
      end
    end
  end

  // pin release once the path drains
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      txd_oe_n <= 1'b1;
    else if (pclken)
    begin
      if (tx_en)
        txd_oe_n <= 1'b0;
      else if (tx_state == usx_pkg::TX_IDLE && !hold_full && !buf_full)
        txd_oe_n <= 1'b1;
    end
  end

  // receiver
  usx_pkg::usx_rx_e rx_state;
  logic [3:0] rcnt, rbit, next_rcnt;
  logic [8:0] rx_shift;
  logic [2:0] rs;
  logic rx_par, maj, bitval, rx_stb, push, push_ok, pop;
  assign maj = (rs[0] & rs[1]) | (rs[1] & rs[2]) | (rs[0] & rs[2]);
  assign bitval = (sync_mode || !rx_mode[1]) ? rxd_in : maj;
  assign rx_stb = sync_mode ? xck_fall : (smp_tick && rcnt == spb_m1);
  assign next_rcnt = !smp_tick ? rcnt : (rcnt == spb_m1) ? 4'd0 : rcnt + 4'd1;
  assign push = rx_en && rx_stb && rx_state == usx_pkg::RX_STOP;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state <= usx_pkg::RX_IDLE;
      rcnt <= '0;
      rbit <= '0;
      rx_shift <= '0;
      rx_par <= 1'b0;
      rs <= 3'h7;
    end
    else if (pclken)
    begin
      if (smp_tick)
        rs <= {rs[1:0], rxd_in};
      if (!rx_en)
      begin
        rx_state <= usx_pkg::RX_IDLE;
        rcnt <= '0;
      end
      else
      begin
        unique case (rx_state)
          usx_pkg::RX_IDLE:
          begin
            rcnt <= '0;
            rbit <= '0;
            rx_shift <= '0;
            if (sync_mode ? (xck_fall && !rxd_in) : (smp_tick && !rxd_in))
              rx_state <= sync_mode ? usx_pkg::RX_DATA : usx_pkg::RX_START;
          end
          usx_pkg::RX_START:
            if (smp_tick)
            begin
              if (rcnt == (spb_m1 >> 1))
              begin
                rcnt <= '0;
                rx_state <= bitval ? usx_pkg::RX_IDLE : usx_pkg::RX_DATA;
              end
              else
                rcnt <= rcnt + 4'd1;
            end
          usx_pkg::RX_DATA:
          begin
            rcnt <= next_rcnt;
            if (rx_stb)
            begin
              rx_shift[rbit] <= bitval;
              rbit <= rbit + 4'd1;
              if (rbit == nbits - 4'd1)
                rx_state <= par_en ? usx_pkg::RX_PAR : usx_pkg::RX_STOP;
            end
          end
          usx_pkg::RX_PAR:
          begin
            rcnt <= next_rcnt;
            if (rx_stb)
            begin
              rx_par <= bitval;
              rx_state <= usx_pkg::RX_STOP;
            end
          end
          usx_pkg::RX_STOP:
          begin
            rcnt <= next_rcnt;
            if (rx_stb)
              rx_state <= usx_pkg::RX_IDLE;
          end
          default:
            rx_state <= usx_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // two-entry receive buffer, entry 0 oldest; flags frame_error_flag, ovf, parity_error_flag
  logic [8:0] rb_data [2];
  logic [2:0] rb_flag [2];
  logic [1:0] rcount, fill;
  logic new_parity_error_flag;
  assign new_parity_error_flag = par_en && (rx_par != ((^rx_shift) ^ parity_mode[0]));
  assign pop = rd && rcount != 2'd0 && addr == ((char_size == usx_pkg::CS_9L) ?
               usx_pkg::OFS_DATA_HIGH : usx_pkg::OFS_DATA_LOW);
  assign push_ok = push && (rcount != 2'd2 || pop);
  assign fill = rcount - {1'b0, pop};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rcount <= '0;
      rb_data[0] <= '0;
      rb_data[1] <= '0;
      rb_flag[0] <= '0;
      rb_flag[1] <= '0;
    end
    else if (pclken)
    begin
      if (!rx_en)
        rcount <= '0;
      else
      begin
        if (pop)
        begin
          rb_data[0] <= rb_data[1];
          rb_flag[0] <= rb_flag[1];
        end
        if (push_ok)
        begin
          rb_data[fill[0]] <= rx_shift;
          rb_flag[fill[0]] <= {~bitval, 1'b0, new_parity_error_flag};
        end
        else if (push)
          rb_flag[1][1] <= 1'b1;
        rcount <= rcount + {1'b0, push_ok} - {1'b0, pop};
      end
    end
  end

  // apb slave: one wait state, effects at the completing edge
  logic [31:0] rdata;
  always_comb
  begin
    rdata = '0;
    unique case (addr)
      usx_pkg::OFS_DATA_LOW: rdata[7:0] = rb_data[0][7:0];
      usx_pkg::OFS_DATA_HIGH:
      begin
        rdata[usx_pkg::RXH_RXC] = rcount != 2'd0;
        // empty buffer shows no stale flags
        if (rcount != 2'd0)
        begin
          rdata[usx_pkg::RXH_OVF] = rb_flag[0][1];
          rdata[usx_pkg::RXH_FRAME_ERROR_FLAG] = rb_flag[0][2];
          rdata[usx_pkg::RXH_PARITY_ERROR_FLAG] = rb_flag[0][0];
          rdata[0] = rb_data[0][8];
        end
      end
      usx_pkg::OFS_STATUS:
      begin
        rdata[usx_pkg::ST_RXC] = rcount != 2'd0;
        rdata[usx_pkg::ST_TXC] = txc;
        rdata[usx_pkg::ST_DRE] = !hold_full;
      end
      usx_pkg::OFS_CTRL: rdata[5:0] = {host_mode, sync_mode, rx_mode, rx_en, tx_en};
      usx_pkg::OFS_FRAME: rdata[6:0] = {stop2, parity_mode, 1'b0, char_size};
      usx_pkg::OFS_BAUD: rdata[15:0] = baud;
      default: rdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else if (pclken)
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready && !pwrite)
        prdata <= rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {host_mode, sync_mode, rx_mode, rx_en, tx_en} <= usx_pkg::CTRL_RESET;
      {stop2, parity_mode, char_size} <= 6'(usx_pkg::FRAME_RESET);
      baud <= usx_pkg::BAUD_RESET;
    end
    else if (pclken && wr)
    begin
      if (addr == usx_pkg::OFS_CTRL)
        {host_mode, sync_mode, rx_mode, rx_en, tx_en} <= pwdata[5:0];
      if (addr == usx_pkg::OFS_FRAME)
        {stop2, parity_mode, char_size} <= {pwdata[6:4], pwdata[2:0]};
      if (addr == usx_pkg::OFS_BAUD)
        baud <= pwdata[15:0];
    end
  end

  // transmit complete: set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      txc <= 1'b0;
    else if (pclken)
    begin
      if (tx_strobe && !txd_oe_n && tx_done && !buf_full && !hold_full)
        txc <= 1'b1;
      else if (wr && addr == usx_pkg::OFS_STATUS && pwdata[usx_pkg::ST_TXC])
        txc <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_buf_ready;
    pclken && buf_full && !txd_oe_n && tx_state == usx_pkg::TX_IDLE && tx_strobe;
  endsequence
  sequence s_start_sent;
    tx_state == usx_pkg::TX_START && !txd_out;
  endsequence

  baud_tick_a: assert property ($past(presetn) && pclken && $past(pclken) && baud == 16'h0040
    && $stable(baud) |-> smp_tick) else $error("sample tick missing at divisor 64");
  host_clock_a: assert property (pclken && sync_mode && host_mode && !half_wrap
    |=> $stable(xck_out)) else $error("host clock toggled early");
  tx_start_a: assert property (s_buf_ready |=> s_start_sent)
    else $error("buffered frame not started");
  tx_complete_a: assert property ($rose(txc)
    |-> $past(!hold_full && !buf_full && tx_state == usx_pkg::TX_STOP))
    else $error("transmit complete with data pending");
  tx_release_a: assert property ($rose(txd_oe_n)
    |-> $past(!tx_en && !hold_full && !buf_full && tx_state == usx_pkg::TX_IDLE))
    else $error("transmit pin released early");
  rx_push_a: assert property (pclken && push && rx_en |=> rcount != 2'd0)
    else $error("received frame not stored");
  rx_order_a: assert property (pclken && pop && !push && rcount == 2'd2
    |=> rb_data[0] == $past(rb_data[1]) && rcount == 2'd1)
    else $error("older frame not presented");
  rx_advance_a: assert property (pclken && rx_en && rd && !push && rcount == 2'd1 &&
    addr == usx_pkg::OFS_DATA_HIGH && char_size != usx_pkg::CS_9L |=> rcount == 2'd1)
    else $error("high byte read advanced buffer");
  rx_flush_a: assert property (pclken && !rx_en
    |=> rcount == 2'd0 && rx_state == usx_pkg::RX_IDLE)
    else $error("receiver disable not immediate");
endmodule

// ### verilog/usx_pkg.sv
// register map, field positions, reset values and types of the serial transceiver
package usx_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_DATA_LOW = 8'h00;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_FRAME = 8'h10;
  localparam logic [7:0] OFS_BAUD = 8'h14;
  // control fields
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_RX_MODE = 2;
  localparam int CTRL_SYNC = 4;
  localparam int CTRL_HOST = 5;
  // frame_control fields
  localparam int FRM_CHARACTER_SIZE = 0;
  localparam int FRM_PARITY = 4;
  localparam int FRM_STOP2 = 6;
  // status fields
  localparam int ST_RXC = 7;
  localparam int ST_TXC = 6;
  localparam int ST_DRE = 5;
  // receive_high_byte fields
  localparam int RXH_RXC = 7;
  localparam int RXH_OVF = 6;
  localparam int RXH_FRAME_ERROR_FLAG = 2;
  localparam int RXH_PARITY_ERROR_FLAG = 1;
  // reset values
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [6:0] FRAME_RESET = 7'h03;
  localparam logic [15:0] BAUD_RESET = 16'h0040;
  // character_size and reception mode codes
  localparam logic [2:0] CS_9L = 3'h6;
  localparam logic [2:0] CS_9H = 3'h7;
  localparam logic [1:0] RXM_DOUBLE = 2'h1;
  // timing counts
  localparam int FRAC_STEP = 64;
  localparam int S_NORMAL = 16;
  localparam int S_DOUBLE = 8;
  localparam int DATA_MAX = 9;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } usx_tx_e;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } usx_rx_e;
endpackage

// ### dv/usx_peer.sv
// remote serial peer: drives frames onto rxd and captures frames from txd
`timescale 1ns/1ps
module usx_peer (
  input wire logic pclk,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;

  // start low, data lsb first, optional parity, stop, then idle high
  task automatic send(input logic [8:0] d, input int n, input int bp, input int pb,
    input logic stop);
    rxd <= 1'b0;
    repeat (bp) @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      rxd <= d[i];
      repeat (bp) @(posedge pclk);
    end
    if (pb >= 0)
    begin
      rxd <= pb[0];
      repeat (bp) @(posedge pclk);
    end
    rxd <= stop;
    repeat (bp) @(posedge pclk);
    rxd <= 1'b1;
    @(posedge pclk);
  endtask

  // waits for a start bit, samples each bit mid-period
  task automatic recv(input int n, input int bp, output logic [8:0] d, output logic stop);
    int k;
    d = 9'h0;
    k = 0;
    while (txd !== 1'b0 && k < 9999)
    begin
      @(posedge pclk);
      k++;
    end
    repeat (bp / 2) @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      repeat (bp) @(posedge pclk);
      d[i] = txd;
    end
    repeat (bp) @(posedge pclk);
    stop = txd;
  endtask
endmodule

// ### dv/tb.sv
// self-checking bench for the serial transceiver core
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic rxd, txd, txd_oe_n, xck_out, xck_oe_n, rerr, stp;
  logic pclken, transfer_clock_pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [8:0] got;
  int cyc;
  int num_errors = 0;
  int total_checks = 0;

  usx_core usx_core_i (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_in(rxd), .txd_out(txd),
    .txd_oe_n(txd_oe_n), .xck_in(transfer_clock_pin), .xck_out(xck_out), .xck_oe_n(xck_oe_n));
  usx_peer usx_peer_i (.pclk(pclk), .txd(txd), .rxd(rxd));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 64)
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 64) num_errors++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr_tx(input logic [31:0] d);
    rd(usx_pkg::OFS_STATUS);
    while (rdat[usx_pkg::ST_DRE] !== 1'b1) rd(usx_pkg::OFS_STATUS);
    wr(usx_pkg::OFS_DATA_LOW, d);
  endtask

  task automatic rx_chk(input logic [31:0] hi, input logic [31:0] lo);
    rd(usx_pkg::OFS_DATA_HIGH);
    chk(rdat, hi);
    rd(usx_pkg::OFS_DATA_LOW);
    chk(rdat, lo);
  endtask

  task automatic t_regs;
    rd(usx_pkg::OFS_CTRL);
    chk(rdat, {26'h0, usx_pkg::CTRL_RESET});
    rd(usx_pkg::OFS_FRAME);
    chk(rdat, {25'h0, usx_pkg::FRAME_RESET});
    rd(usx_pkg::OFS_BAUD);
    chk(rdat, {16'h0, usx_pkg::BAUD_RESET});
    rd(usx_pkg::OFS_STATUS);
    chk(rdat, 32'h20);
    rd(8'h18);
    chk(32'(rerr), 32'h1);
  endtask

  task automatic t_tx;
    wr(usx_pkg::OFS_CTRL, 32'h1);
    wr(usx_pkg::OFS_BAUD, 32'h60);
    fork
      begin
        wr_tx(32'ha5);
        wr_tx(32'h3c);
      end
      begin
        usx_peer_i.recv(8, 24, got, stp);
        chk(32'({stp, got}), 32'h2a5);
        usx_peer_i.recv(8, 24, got, stp);
        chk(32'({stp, got}), 32'h23c);
      end
    join
    repeat (24) @(posedge pclk);
    rd(usx_pkg::OFS_STATUS);
    chk(rdat, 32'h60);
    wr(usx_pkg::OFS_STATUS, 32'h40);
    rd(usx_pkg::OFS_STATUS);
    chk(rdat, 32'h20);
    wr(usx_pkg::OFS_FRAME, 32'h0);
    fork
      wr_tx(32'hff);
      usx_peer_i.recv(5, 24, got, stp);
    join
    chk(32'({stp, got}), 32'h21f);
    fork
      begin
        wr_tx(32'h0a);
        wr(usx_pkg::OFS_CTRL, 32'h0);
        chk(32'(txd_oe_n), 32'h0);
      end
      usx_peer_i.recv(5, 24, got, stp);
    join
    chk(32'(got), 32'h0a);
    repeat (24) @(posedge pclk);
    chk(32'(txd_oe_n), 32'h1);
  endtask

  task automatic t_rx;
    wr(usx_pkg::OFS_FRAME, 32'h3);
    wr(usx_pkg::OFS_BAUD, 32'h40);
    for (int m = 0; m < 4; m++)
    begin
      wr(usx_pkg::OFS_CTRL, 32'(m * 4 + 2));
      usx_peer_i.send(9'(8'h5a ^ m), 8, (m == 1) ? 8 : 16, -1, 1'b1);
      rx_chk(32'h80, 32'(8'h5a ^ m));
    end
    wr(usx_pkg::OFS_CTRL, 32'h2);
    usx_peer_i.send(9'h11, 8, 16, -1, 1'b1);
    usx_peer_i.send(9'h22, 8, 16, -1, 1'b1);
    usx_peer_i.send(9'h33, 8, 16, -1, 1'b1);
    rx_chk(32'h80, 32'h11);
    rx_chk(32'hc0, 32'h22);
    rd(usx_pkg::OFS_DATA_HIGH);
    chk(rdat, 32'h0);
  endtask

  task automatic t_err;
    wr(usx_pkg::OFS_FRAME, 32'h23);
    usx_peer_i.send(9'h07, 8, 16, 0, 1'b1);
    rx_chk(32'h82, 32'h07);
    usx_peer_i.send(9'h07, 8, 16, 1, 1'b0);
    rx_chk(32'h84, 32'h07);
    wr(usx_pkg::OFS_FRAME, 32'h33);
    usx_peer_i.send(9'h07, 8, 16, 0, 1'b1);
    rx_chk(32'h80, 32'h07);
    wr(usx_pkg::OFS_FRAME, 32'h43);
    usx_peer_i.send(9'h5, 8, 16, -1, 1'b1);
    rx_chk(32'h80, 32'h05);
  endtask

  task automatic t_nine;
    wr(usx_pkg::OFS_FRAME, {29'h0, usx_pkg::CS_9L});
    usx_peer_i.send(9'h155, 9, 16, -1, 1'b1);
    usx_peer_i.send(9'h0aa, 9, 16, -1, 1'b1);
    rd(usx_pkg::OFS_DATA_LOW);
    rd(usx_pkg::OFS_DATA_LOW);
    chk(rdat, 32'h55);
    rd(usx_pkg::OFS_DATA_HIGH);
    chk(rdat, 32'h81);
    rd(usx_pkg::OFS_DATA_LOW);
    chk(rdat, 32'haa);
    wr(usx_pkg::OFS_CTRL, 32'h3);
    fork
      begin
        wr(usx_pkg::OFS_DATA_LOW, 32'h55);
        wr(usx_pkg::OFS_DATA_HIGH, 32'h1);
      end
      usx_peer_i.recv(9, 16, got, stp);
    join
    chk(32'({stp, got}), 32'h355);
  endtask

  task automatic t_flush;
    wr(usx_pkg::OFS_FRAME, 32'h3);
    usx_peer_i.send(9'h44, 8, 16, -1, 1'b1);
    fork
      usx_peer_i.send(9'h66, 8, 16, -1, 1'b1);
      begin
        repeat (60) @(posedge pclk);
        wr(usx_pkg::OFS_CTRL, 32'h0);
      end
    join
    wr(usx_pkg::OFS_CTRL, 32'h2);
    rd(usx_pkg::OFS_DATA_HIGH);
    chk(rdat, 32'h0);
  endtask

  task automatic lvl(input logic v);
    while (xck_out !== v && cyc < 99)
    begin
      @(posedge pclk);
      cyc++;
    end
  endtask

  task automatic t_sync;
    logic [10:0] sh;
    wr(usx_pkg::OFS_BAUD, 32'h80);
    wr(usx_pkg::OFS_CTRL, 32'h31);
    @(posedge pclk);
    chk(32'(xck_oe_n), 32'h0);
    cyc = 0;
    lvl(1'b0);
    lvl(1'b1);
    cyc = 0;
    lvl(1'b0);
    lvl(1'b1);
    chk(32'(cyc), 32'h4);
    pclken <= 1'b0;
    @(posedge pclk);
    sh[0] = xck_out;
    repeat (6) @(posedge pclk);
    chk(32'(xck_out), 32'(sh[0]));
    pclken <= 1'b1;
    wr(usx_pkg::OFS_CTRL, 32'h0);
    @(posedge pclk);
    chk(32'(xck_oe_n), 32'h1);
    wr(usx_pkg::OFS_CTRL, 32'h11);
    wr_tx(32'h96);
    for (int i = 0; i < 11; i++)
    begin
      transfer_clock_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      sh[i] = txd;
      transfer_clock_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    chk(32'(sh), 32'h72c);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    presetn = 1'b0;
    pclken = 1'b1;
    transfer_clock_pin = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_tx();
    t_rx();
    t_err();
    t_nine();
    t_flush();
    t_sync();
    wrap_up();
  end

  initial
  begin
    #300000;
    num_errors++;
    wrap_up();
  end
endmodule
